// file: rtl/sebs_eeprom_slave.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// small fifo, pointers carry one extra wrap bit
module sebs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } sebs_fifo_ptr_s;

    sebs_fifo_ptr_s   ptr_reg;
    sebs_fifo_ptr_s   ptr_next;
    logic [WIDTH-1:0] store [DEPTH];

    // full when pointers differ only in the wrap bit
    assign in_ready  = (ptr_reg.wptr ^ ptr_reg.rptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = ptr_reg.wptr != ptr_reg.rptr;
    assign out_data  = store[ptr_reg.rptr[AW-1:0]];

    // pointer advance on each handshake
    always_comb begin
        ptr_next = ptr_reg;
        if (in_valid && in_ready) begin
            ptr_next.wptr = ptr_reg.wptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            ptr_next.rptr = ptr_reg.rptr + 1'b1;
        end
        if (clear) begin
            ptr_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ptr_reg <= '0;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge clock) begin
        if (in_valid && in_ready) begin
            store[ptr_reg.wptr[AW-1:0]] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// two-wire eeprom slave, bus clock found by oversampling
module sebs_eeprom_slave
    import sebs_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = SEBS_PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic por_active,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_select_strap_low,
    input  wire logic chip_select_strap_high,
    input  wire logic write_inhibit_pin,
    output logic      prog_busy
);
    sebs_regs_s             r_reg;
    sebs_regs_s             r_next;
    sebs_pins_s             pins;
    logic [7:0]             mem [SEBS_MEM_DEPTH];
    logic [7:0]             pbuf [SEBS_PAGE_BYTES];
    logic [7:0]             mem_rd;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_cond;
    logic                   stop_cond;
    logic                   por;
    logic                   fifo_in_valid;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    logic [SEBS_FIFO_W-1:0] fifo_out_data;
    logic                   mem_we;
    logic                   ack_slot;

    // select byte check: type, fixed zero, both straps
    function automatic logic sebs_dev_match(input logic [7:0] b, input sebs_pins_s p);
        return (b[7:4] == SEBS_TYPE_CODE) && !b[3] && (b[2:1] == {p.cs_hi, p.cs_lo});
    endfunction

    // straps rely on pad pull-downs so a floating pin arrives low
    assign pins = '{por: por_active, cs_hi: chip_select_strap_high,
                    cs_lo: chip_select_strap_low, wc: write_inhibit_pin,
                    sda: sda_in, scl: scl_in};

    // edges and conditions only from the second sync stage
    assign scl_rise   = r_reg.sync2.scl && !r_reg.prev.scl;
    assign scl_fall   = !r_reg.sync2.scl && r_reg.prev.scl;
    assign start_cond = r_reg.sync2.scl && r_reg.prev.scl && r_reg.prev.sda && !r_reg.sync2.sda;
    assign stop_cond  = r_reg.sync2.scl && r_reg.prev.scl && !r_reg.prev.sda && r_reg.sync2.sda;
    assign por        = r_reg.sync2.por;
    assign ack_slot   = scl_fall && (r_reg.cnt == SEBS_CNT_ACK);
    assign mem_rd     = mem[r_reg.addr];

    // only pull low, never drive high
    assign sda_out   = 1'b0;
    assign sda_oe    = r_reg.oe;
    assign prog_busy = r_reg.st inside {SEBS_FLUSH, SEBS_PROG};

    // page buffer drain stalls during programming so the fifo backs up
    assign fifo_out_ready = (r_reg.st != SEBS_PROG);
    assign mem_we = (r_reg.st == SEBS_PROG) && (r_reg.prog_cnt < 32'(SEBS_PAGE_BYTES))
                    && r_reg.valid[r_reg.prog_cnt[SEBS_PAGE_W-1:0]];

    sebs_fifo #(
        .WIDTH (SEBS_FIFO_W),
        .DEPTH (SEBS_FIFO_DEPTH)
    ) u_wfifo (
        .clock     (clock),
        .resetn    (resetn),
        .clear     (por),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({r_reg.addr[SEBS_PAGE_W-1:0], r_reg.sh}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // protocol engine
    always_comb begin
        r_next        = r_reg;
        r_next.sync1  = pins;
        r_next.sync2  = r_reg.sync1;
        r_next.prev   = r_reg.sync2;
        fifo_in_valid = 1'b0;
        if (fifo_out_valid && fifo_out_ready) begin
            r_next.valid[fifo_out_data[SEBS_FIFO_W-1:8]] = 1'b1;
        end
        if (por) begin
            // lockout: drop the transfer and the pending page; the address register is kept
            r_next.st         = SEBS_IDLE;
            r_next.oe         = 1'b0;
            r_next.cnt        = 4'h0;
            r_next.wr_pending = 1'b0;
            r_next.valid      = '0;
        end else if (r_reg.st == SEBS_PROG) begin
            // copy page in first cycles, then wait out the write time
            r_next.prog_cnt = r_reg.prog_cnt + 32'h0000_0001;
            if (r_reg.prog_cnt >= PROG_CYCLES - 1) begin
                r_next.st         = SEBS_IDLE;
                r_next.valid      = '0;
                r_next.wr_pending = 1'b0;
            end
        end else if (r_reg.st == SEBS_FLUSH) begin
            if (!fifo_out_valid) begin
                r_next.st       = SEBS_PROG;
                r_next.prog_cnt = 32'h0000_0000;
            end
        end else if (start_cond) begin
            r_next.st  = SEBS_DEV;
            r_next.cnt = 4'h0;
            r_next.oe  = 1'b0;
            r_next.wp  = r_reg.sync2.wc;
        end else if (stop_cond) begin
            r_next.oe  = 1'b0;
            r_next.cnt = 4'h0;
            r_next.st  = r_reg.wr_pending ? SEBS_FLUSH : SEBS_IDLE;
        end else if (r_reg.st != SEBS_IDLE && scl_rise) begin
            if (r_reg.cnt < SEBS_CNT_ACK) begin
                if (r_reg.st != SEBS_RDATA) begin
                    r_next.sh = {r_reg.sh[6:0], r_reg.sync2.sda};
                end
            end else if (r_reg.cnt == SEBS_CNT_ACK) begin
                r_next.mnack = r_reg.sync2.sda;
            end
            r_next.cnt = r_reg.cnt + 4'h1;
            // inhibit is sampled at start, then watched through both address bytes
            if (r_reg.st inside {SEBS_ADRH, SEBS_ADRL}) begin
                r_next.wp = r_reg.wp | r_reg.sync2.wc;
            end
        end else if (r_reg.st != SEBS_IDLE && scl_fall) begin
            if (r_reg.cnt == SEBS_CNT_ACK) begin
                unique case (r_reg.st)
                    SEBS_DEV: begin
                        if (sebs_dev_match(r_reg.sh, r_reg.sync2)) begin
                            r_next.oe    = 1'b1;
                            r_next.after = r_reg.sh[0] ? SEBS_RDATA : SEBS_ADRH;
                        end else begin
                            r_next.st = SEBS_IDLE;
                        end
                    end
                    SEBS_ADRH: begin
                        r_next.addr[14:8] = r_reg.sh[6:0];
                        r_next.oe         = 1'b1;
                        r_next.after      = SEBS_ADRL;
                    end
                    SEBS_ADRL: begin
                        r_next.addr[7:0] = r_reg.sh;
                        r_next.oe        = 1'b1;
                        r_next.after     = SEBS_WDATA;
                    end
                    SEBS_WDATA: begin
                        // a full fifo refuses the byte with a nack
                        if (!r_reg.wp && fifo_in_ready) begin
                            fifo_in_valid     = 1'b1;
                            r_next.wr_pending = 1'b1;
                            r_next.oe         = 1'b1;
                            r_next.after      = SEBS_WDATA;
                            // roll over inside the 64 byte page
                            r_next.addr[SEBS_PAGE_W-1:0] =
                                r_reg.addr[SEBS_PAGE_W-1:0] + 6'h01;
                        end else begin
                            r_next.after = SEBS_IDLE;
                        end
                    end
                    SEBS_RDATA: r_next.oe = 1'b0;
                    default:    r_next.st = SEBS_IDLE;
                endcase
            end else if (r_reg.cnt == SEBS_CNT_DONE) begin
                r_next.cnt = 4'h0;
                r_next.oe  = 1'b0;
                if ((r_reg.st == SEBS_RDATA && !r_reg.mnack)
                    || (r_reg.st == SEBS_DEV && r_reg.after == SEBS_RDATA)) begin
                    // load next byte and drive its msb
                    r_next.st   = SEBS_RDATA;
                    r_next.sh   = mem_rd;
                    r_next.oe   = !mem_rd[7];
                    r_next.addr = r_reg.addr + 15'h0001;
                end else if (r_reg.st == SEBS_RDATA) begin
                    r_next.st = SEBS_IDLE;
                end else begin
                    r_next.st = r_reg.after;
                end
            end else if (r_reg.st == SEBS_RDATA && r_reg.cnt != 4'h0) begin
                r_next.sh = {r_reg.sh[6:0], 1'b0};
                r_next.oe = !r_reg.sh[6];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            r_reg            <= '0;
            r_reg.sync1      <= SEBS_PINS_RESET;
            r_reg.sync2      <= SEBS_PINS_RESET;
            r_reg.prev       <= SEBS_PINS_RESET;
            r_reg.st         <= SEBS_IDLE;
            r_reg.after      <= SEBS_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // page buffer fill and array commit, no reset on storage
    always_ff @(posedge clock) begin
        if (fifo_out_valid && fifo_out_ready) begin
            pbuf[fifo_out_data[SEBS_FIFO_W-1:8]] <= fifo_out_data[7:0];
        end
        if (mem_we) begin
            mem[{r_reg.addr[SEBS_ADDR_W-1:SEBS_PAGE_W], r_reg.prog_cnt[SEBS_PAGE_W-1:0]}] <=
                pbuf[r_reg.prog_cnt[SEBS_PAGE_W-1:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    logic dev_ack_slot;
    assign dev_ack_slot = !por && ack_slot && r_reg.st == SEBS_DEV && !start_cond && !stop_cond;

    property p_type_ack;
        dev_ack_slot && sebs_dev_match(r_reg.sh, r_reg.sync2) |=> sda_oe ##1 sda_oe;
    endproperty
    a_type_ack: assert property (p_type_ack) else $error("select match not acked");

    property p_type_reject;
        dev_ack_slot && r_reg.sh[7:4] != SEBS_TYPE_CODE |=> !sda_oe && r_reg.st == SEBS_IDLE;
    endproperty
    a_type_reject: assert property (p_type_reject) else $error("wrong type acked");

    property p_strap_reject;
        dev_ack_slot && r_reg.sh[2:1] != {r_reg.sync2.cs_hi, r_reg.sync2.cs_lo}
            |=> !sda_oe;
    endproperty
    a_strap_reject: assert property (p_strap_reject) else $error("strap mismatch acked");

    property p_inhibit_nack;
        ack_slot && !por && r_reg.st == SEBS_WDATA && r_reg.wp
            |=> !sda_oe && r_reg.wr_pending == $past(r_reg.wr_pending);
    endproperty
    a_inhibit_nack: assert property (p_inhibit_nack) else $error("inhibited data acked");

    property p_por_lock;
        por |=> r_reg.st == SEBS_IDLE && !sda_oe && r_reg.valid == '0;
    endproperty
    a_por_lock: assert property (p_por_lock) else $error("activity under power-on reset");

    property p_prog_silent;
        r_reg.st == SEBS_PROG |-> !sda_oe;
    endproperty
    a_prog_silent: assert property (p_prog_silent) else $error("ack during programming");

    property p_stop_starts_prog;
        !por && stop_cond && r_reg.wr_pending && !(r_reg.st inside {SEBS_FLUSH, SEBS_PROG})
            |=> r_reg.st == SEBS_FLUSH ##[1:20] r_reg.st == SEBS_PROG;
    endproperty
    a_stop_starts_prog: assert property (p_stop_starts_prog) else $error("no prog on stop");

    property p_open_drain;
        sda_oe |-> !sda_out && (r_reg.st inside {SEBS_DEV, SEBS_ADRH, SEBS_ADRL,
                                                  SEBS_WDATA, SEBS_RDATA});
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven out of place");

    property p_seq_inc;
        scl_fall && !por && r_reg.st == SEBS_RDATA && r_reg.cnt == SEBS_CNT_DONE && !r_reg.mnack
            && !start_cond |=> r_reg.addr == $past(r_reg.addr) + 15'h0001;
    endproperty
    a_seq_inc: assert property (p_seq_inc) else $error("read address not advanced");

    property p_page_wrap;
        fifo_in_valid |=> r_reg.addr[14:6] == $past(r_reg.addr[14:6]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page write left its page");

    property p_sample_rise;
        !por && scl_rise && r_reg.st == SEBS_DEV && r_reg.cnt < SEBS_CNT_ACK && !start_cond
            && !stop_cond |=> r_reg.sh[0] == $past(r_reg.sync2.sda);
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled on rise");

    c_read_done:  cover property (r_reg.st == SEBS_RDATA ##1 r_reg.st == SEBS_IDLE);
    c_prog_done:  cover property (r_reg.st == SEBS_PROG ##1 r_reg.st == SEBS_IDLE);
    c_inhibited:  cover property (ack_slot && r_reg.st == SEBS_WDATA && r_reg.wp);
    c_mismatch:   cover property (dev_ack_slot ##1 r_reg.st == SEBS_IDLE);
endmodule

// file: shared/sebs_pkg.sv
// Operation
// - respond only when select byte upper nibble equals type code 1010
// - device pulls data low in ninth bit after each received byte
// - power-on reset active disables all operations and ignores every command
// - select bits b2 and b1 must match the two strap inputs
// - an unconnected strap input reads as logic low
// - write-inhibit low allows array writes; high blocks all writes; the code samples it only at start and through both address bytes
// - data line is open drain: only pulled low or released
// - storage array holds 32K bytes of eight bits each
// - byte writes and page writes of up to 64 bytes
// - random reads and sequential reads with auto-incremented address
// - bits sampled and shifted by the bus serial clock only
// - up to four devices share a bus, told apart by straps
// - select byte msb first: type, zero, straps, read/write in b0
// - write-inhibited: ack select and address, nack data, memory unchanged
// - 16-bit address, high byte first; top bit b15 ignored
// - stop closing a write starts the self-timed programming cycle
package sebs_pkg;

    localparam logic [3:0]  SEBS_TYPE_CODE      = 4'ha;
    localparam int          SEBS_ADDR_W         = 15;
    localparam int          SEBS_MEM_DEPTH      = 32768;
    localparam int          SEBS_PAGE_BYTES     = 64;
    localparam int          SEBS_PAGE_W         = 6;
    localparam int          SEBS_FIFO_DEPTH     = 16;
    localparam int          SEBS_FIFO_W         = 14;
    localparam logic [3:0]  SEBS_CNT_ACK        = 4'h8;
    localparam logic [3:0]  SEBS_CNT_DONE       = 4'h9;
    localparam int          SEBS_CLK_PERIOD_NS  = 10;
    localparam int          SEBS_PROG_TIME_NS   = 5_000_000;
    localparam int          SEBS_PROG_CYCLES    =
        (SEBS_PROG_TIME_NS + SEBS_CLK_PERIOD_NS - 1) / SEBS_CLK_PERIOD_NS;

    typedef enum logic [7:0] {
        SEBS_IDLE  = 8'h01,
        SEBS_DEV   = 8'h02,
        SEBS_ADRH  = 8'h04,
        SEBS_ADRL  = 8'h08,
        SEBS_WDATA = 8'h10,
        SEBS_RDATA = 8'h20,
        SEBS_FLUSH = 8'h40,
        SEBS_PROG  = 8'h80
    } sebs_state_e;

    typedef struct packed {
        logic por;
        logic cs_hi;
        logic cs_lo;
        logic wc;
        logic sda;
        logic scl;
    } sebs_pins_s;

    typedef struct packed {
        sebs_pins_s                 sync1;
        sebs_pins_s                 sync2;
        sebs_pins_s                 prev;
        sebs_state_e                st;
        sebs_state_e                after;
        logic [3:0]                 cnt;
        logic [7:0]                 sh;
        logic [SEBS_ADDR_W-1:0]     addr;
        logic                       wp;
        logic                       mnack;
        logic                       wr_pending;
        logic                       oe;
        logic [31:0]                prog_cnt;
        logic [SEBS_PAGE_BYTES-1:0] valid;
    } sebs_regs_s;

    localparam sebs_pins_s SEBS_PINS_RESET = '{por: 1'b1, cs_hi: 1'b0, cs_lo: 1'b0,
                                              wc: 1'b0, sda: 1'b1, scl: 1'b1};

endpackage

// file: verification/sebs_master_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// two-wire bus master, each bit is four quarters of 4 system clocks (160 ns)
module sebs_master_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // quarter bit; every change lands on a falling system edge
    task automatic q(input int n);
        repeat (n * 4) @(negedge clock);
    endtask

    // start or repeated start, leaves clock low
    task automatic start();
        q(1);
        sda_drv = 1'b1;
        q(1);
        scl_drv = 1'b1;
        q(2);
        sda_drv = 1'b0;
        q(2);
        scl_drv = 1'b0;
    endtask

    // stop from clock low
    task automatic stop();
        q(1);
        sda_drv = 1'b0;
        q(1);
        scl_drv = 1'b1;
        q(2);
        sda_drv = 1'b1;
        q(2);
    endtask

    // data set mid-low, sampled mid-high, so it is stable across both edges
    task automatic bit_io(input logic d, output logic s);
        q(1);
        sda_drv = d;
        q(1);
        scl_drv = 1'b1;
        q(1);
        s = sda_line;
        q(1);
        scl_drv = 1'b0;
    endtask

    // byte out msb first, then the ninth bit; tx ff releases for a read
    task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                        output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ai, ao);
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module tb_top
    import sebs_pkg::*;
;
    localparam int unsigned PROG = 400;

    logic       clock      = 1'b0;
    logic       resetn     = 1'b0;
    logic       por_active = 1'b0;
    logic       cs_hi      = 1'b0;
    logic       cs_lo      = 1'b0;
    logic       wi         = 1'b0;
    logic       scl_drv;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe;
    logic       prog_busy;
    int         err_total  = 0;
    int         n_checks   = 0;
    int         busy_len   = 0;
    int         last_len   = 0;
    logic [7:0] shadow [0:32767];
    wire        sda_line   = sda_drv & (sda_oe ? sda_out : 1'b1);

    always #(SEBS_CLK_PERIOD_NS / 2) clock = ~clock;

    sebs_master_model u_mst (.clock(clock), .sda_line(sda_line), .scl_drv(scl_drv),
                             .sda_drv(sda_drv));

    sebs_eeprom_slave #(.PROG_CYCLES(PROG)) dut (
        .clock(clock), .resetn(resetn), .por_active(por_active), .scl_in(scl_drv),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_strap_low(cs_lo), .chip_select_strap_high(cs_hi),
        .write_inhibit_pin(wi), .prog_busy(prog_busy));

    // length of each busy period, kept after it ends;
    // sampled off the launching edge so busy has settled
    always @(negedge clock) begin
        if (prog_busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            last_len <= busy_len;
            busy_len <= 0;
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic sel(input logic [7:0] code, output logic ak);
        logic [7:0] rx;
        u_mst.start();
        u_mst.xfer(code, 1'b1, rx, ak);
    endtask

    // select for write and both address bytes, b15 sent as one
    task automatic put_addr(input logic [14:0] a);
        logic       ak;
        logic [7:0] rx;
        sel({SEBS_TYPE_CODE, 1'b0, cs_hi, cs_lo, 1'b0}, ak);
        `CHK("sel ack", 1'b0, ak)
        u_mst.xfer({1'b1, a[14:8]}, 1'b1, rx, ak);
        `CHK("adh ack", 1'b0, ak)
        u_mst.xfer(a[7:0], 1'b1, rx, ak);
        `CHK("adl ack", 1'b0, ak)
    endtask

    // a start while busy must go unanswered; then the busy length is checked
    task automatic wait_prog(input logic busy_exp);
        int   k;
        logic ak;
        k = 0;
        while (prog_busy !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        `CHK("busy rise", busy_exp, prog_busy)
        if (busy_exp) begin
            sel({SEBS_TYPE_CODE, 1'b0, cs_hi, cs_lo, 1'b0}, ak);
            `CHK("busy nack", 1'b1, ak)
            u_mst.stop();
            k = 0;
            while (prog_busy !== 1'b0 && k < PROG + 200) begin
                @(negedge clock);
                k++;
            end
            if (k >= PROG + 200) begin
                err_total++;
                results();
            end
            repeat (2) @(negedge clock);
            `CHK("busy len", 1'b1, last_len >= PROG && last_len < PROG + 80)
        end
    endtask

    // page offset wraps in the low six bits; inhibited data is refused
    task automatic wr(input logic [14:0] a, input int n, input logic [7:0] seed);
        logic        ak;
        logic [7:0]  rx;
        logic [14:0] p;
        put_addr(a);
        for (int i = 0; i < n; i++) begin
            p = {a[14:6], 6'(a[5:0] + i)};
            u_mst.xfer(p[7:0] ^ seed, 1'b1, rx, ak);
            `CHK("data ack", wi, ak)
            if (!wi) shadow[p] = p[7:0] ^ seed;
        end
        u_mst.stop();
        wait_prog(!wi);
    endtask

    // random read, sequential over the full address, master nacks the last
    task automatic rd(input logic [14:0] a, input int n);
        logic       ak;
        logic [7:0] rx;
        put_addr(a);
        sel({SEBS_TYPE_CODE, 1'b0, cs_hi, cs_lo, 1'b1}, ak);
        `CHK("rsel ack", 1'b0, ak)
        for (int i = 0; i < n; i++) begin
            u_mst.xfer(8'hff, i == n - 1, rx, ak);
            `CHK("rdata", shadow[15'(a + i)], rx)
        end
        u_mst.stop();
        `CHK("oe idle", 1'b0, sda_oe)
    endtask

    initial begin
        logic       ak;
        logic [7:0] rx;
        repeat (4) @(negedge clock);
        `CHK("oe reset", 1'b0, sda_oe)
        `CHK("busy reset", 1'b0, prog_busy)
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        wr(15'h1234, 1, 8'h3c);
        rd(15'h1234, 1);
        $display("test byte done");
        wr(15'h0542, 64, 8'ha5);
        rd(15'h0540, 63);
        sel({SEBS_TYPE_CODE, 1'b0, cs_hi, cs_lo, 1'b1}, ak);
        u_mst.xfer(8'hff, 1'b1, rx, ak);
        `CHK("cur read", shadow[15'h057f], rx)
        u_mst.stop();
        $display("test page done");
        wr(15'h7fff, 1, 8'h11);
        wr(15'h0000, 1, 8'h22);
        rd(15'h7fff, 2);
        $display("test wrap done");
        wi = 1'b1;
        wr(15'h1234, 1, 8'hc3);
        wi = 1'b0;
        rd(15'h1234, 1);
        $display("test inhibit done");
        // every strap pattern against every select, bad type and b3 set
        for (int s = 0; s < 4; s++) begin
            {cs_hi, cs_lo} = 2'(s);
            for (int c = 0; c < 6; c++) begin
                sel(c < 4 ? {SEBS_TYPE_CODE, 1'b0, 2'(c), 1'b0} : (c == 4 ? 8'hb0 : 8'ha8), ak);
                `CHK("strap ack", c != s, ak)
                u_mst.stop();
            end
        end
        {cs_hi, cs_lo} = 2'b00;
        $display("test select done");
        por_active = 1'b1;
        repeat (4) @(negedge clock);
        sel({SEBS_TYPE_CODE, 4'h0}, ak);
        `CHK("por nack", 1'b1, ak)
        u_mst.stop();
        por_active = 1'b0;
        repeat (4) @(negedge clock);
        rd(15'h1234, 1);
        `CHK("sda out", 1'b0, sda_out)
        $display("test por done");
        results();
    end
endmodule
